// >>> hw/dtm_regs.svh
// register offsets, fields, reset values and timing counts of the thermal monitor
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
`define DTM_NUM_THR 6
`define DTM_ADDR_W 4
// register byte addresses
`define DTM_CTRL_OFS 4'h0
`define DTM_FLAG_OFS 4'h4
`define DTM_MASK_OFS 4'h8
`define DTM_STAT_OFS 4'hC
// control fields
`define DTM_CTRL_EN_BIT 0
`define DTM_CTRL_AON_BIT 1
`define DTM_CTRL_STBY_BIT 2
// status fields
`define DTM_STAT_SENSE_LSB 0
`define DTM_STAT_SD_BIT 6
`define DTM_STAT_ON_BIT 7
// reset values
`define DTM_CTRL_RST 3'h1
`define DTM_MASK_RST 6'h3F
// thresholds in degrees celsius, packed 8 bits each, lowest first
`define DTM_THR_C 48'h9B_8C_7D_6E_5F_50
`define DTM_SD_C 8'hA5
`define DTM_WARN_HYS_C 8'h05
`define DTM_SD_HYS_C 8'h0F
// times
`define DTM_CLK_MHZ 250
`define DTM_DB_US 10
`define DTM_WIN_US 450
`define DTM_INT_US 3000
`define DTM_DB_CYC (`DTM_DB_US * `DTM_CLK_MHZ)
`define DTM_WIN_CYC (`DTM_WIN_US * `DTM_CLK_MHZ)
`define DTM_INT_CYC (`DTM_INT_US * `DTM_CLK_MHZ)
`endif

// >>> hw/dtm_pkg.sv
// types of the thermal monitor
package dtm_pkg;
  typedef enum logic [2:0]
  {
    DTM_OFF = 3'b001,
    DTM_WIN = 3'b010,
    DTM_IDLE = 3'b100
  } dtm_pwr_e;
  typedef logic [7:0] dtm_temp_t;
endpackage

// >>> hw/dtm_cmp_if.sv
// comparator link between the control top and the debounce unit
`timescale 1ns/1ps
interface dtm_cmp_if;
  logic [6:0] raw;
  logic [6:0] stable;
  logic sample;
  modport ctrl (output raw, output sample, input stable);
  modport filt (input raw, input sample, output stable);
endinterface

// >>> hw/dtm_debounce.sv
// debounce filter for the threshold comparisons
`timescale 1ns/1ps
`include "dtm_regs.svh"
module dtm_debounce
  import dtm_pkg::*;
#(
  parameter int N = 7,
  parameter int DB_CYC = `DTM_DB_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  dtm_cmp_if.filt cmp
);
  initial
  begin
    if (DB_CYC < 1 || DB_CYC > 65535 || N != 7)
      $error("dtm_debounce: unsupported parameters");
  end
  logic [15:0] cnt_q [N];
  logic [N-1:0] stable_q;
  assign cmp.stable = stable_q;
  for (genvar i = 0; i < N; i++)
  begin : g_db
    wire differs = cmp.raw[i] != stable_q[i];
    wire done = cnt_q[i] == 16'(DB_CYC - 1);
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cnt_q[i] <= 16'h0000;
      else if (!cmp.sample || !differs)
        cnt_q[i] <= 16'h0000;
      else if (!done)
        cnt_q[i] <= cnt_q[i] + 16'h0001;
    end
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        stable_q[i] <= 1'b0;
      else if (cmp.sample && differs && done)
        stable_q[i] <= cmp.raw[i];
    end
  end
endmodule

// >>> hw/dtm_top.sv
// thermal monitor control: thresholds, flags, sampling schedule, bus slave
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "dtm_regs.svh"
// Functional notes
// - only the centre-of-die reading drives warnings and shutdown
// - six warning thresholds 80 to 155 C, each with flag, sense, mask
// - crossing a warning threshold sets its interrupt flag
// - sense releases only 5 C below its threshold
// - shutdown at 165 C, restart blocked until 15 C cooler
// - every comparison debounced about 10 us both directions
// - monitor disabled while enable bit is 0
// - run state: always-on bit keeps monitor powered, else sampling
// - sampling: on 450 us every 3.0 ms
// - standby: sampling only, and only while enabled
// - active-low interrupt pin asserts for any unmasked set flag
// - sense bit follows its condition, independent of the flag
module dtm_top
  import dtm_pkg::*;
#(
  parameter int DB_CYC = `DTM_DB_CYC,
  parameter int WIN_CYC = `DTM_WIN_CYC,
  parameter int INT_CYC = `DTM_INT_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] center_temp_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_out_n,
  output logic monitor_power_o,
  output logic thermal_shutdown_o
);
  initial
  begin
    if (WIN_CYC < 1 || INT_CYC <= WIN_CYC || INT_CYC > 2**20)
      $error("dtm_top: unsupported sampling parameters");
  end

  // ************************************************************
  // register bus
  // ************************************************************
  logic [2:0] ctrl_q;
  logic [5:0] temp_irq_flag_q;
  logic [5:0] thermal_threshold_irq_mask_q;
  logic ack_q;
  logic [31:0] rdat_q;
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wr && wb_adr_i == `DTM_CTRL_OFS;
  wire wr_flag = wr && wb_adr_i == `DTM_FLAG_OFS;
  wire wr_mask = wr && wb_adr_i == `DTM_MASK_OFS;
  wire temp_monitor_enable = ctrl_q[`DTM_CTRL_EN_BIT];
  wire temp_monitor_always_on = ctrl_q[`DTM_CTRL_AON_BIT];
  wire standby = ctrl_q[`DTM_CTRL_STBY_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= `DTM_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      thermal_threshold_irq_mask_q <= `DTM_MASK_RST;
    else if (wr_mask)
      thermal_threshold_irq_mask_q <= wb_dat_i[5:0];
  end

  // ************************************************************
  // sampling schedule
  // ************************************************************
  dtm_pwr_e pwr_q;
  dtm_pwr_e pwr_d;
  logic [19:0] tick_q;
  wire sampling = standby || !temp_monitor_always_on;
  wire int_end = tick_q == 20'(INT_CYC - 1);
  wire win_end = tick_q == 20'(WIN_CYC - 1);

  always_comb
  begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      DTM_OFF:
        if (temp_monitor_enable)
          pwr_d = DTM_WIN;
      DTM_WIN:
        if (!temp_monitor_enable)
          pwr_d = DTM_OFF;
        else if (sampling && win_end)
          pwr_d = DTM_IDLE;
      DTM_IDLE:
        if (!temp_monitor_enable)
          pwr_d = DTM_OFF;
        else if (!sampling || int_end)
          pwr_d = DTM_WIN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwr_q <= DTM_OFF;
    else
      pwr_q <= pwr_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || pwr_q == DTM_OFF || int_end || !sampling)
      tick_q <= 20'h00000;
    else
      tick_q <= tick_q + 20'h00001;
  end

  wire powered = pwr_q == DTM_WIN;

  // ************************************************************
  // comparisons with hysteresis
  // ************************************************************
  function automatic logic hys_cmp(input dtm_temp_t t, input dtm_temp_t thr,
                                   input dtm_temp_t hys, input logic cur);
    logic r;
    r = cur ? (t > thr - hys) : (t >= thr);
    return r;
  endfunction

  dtm_cmp_if cmp ();
  logic [6:0] raw;
  always_comb
  begin
    for (int i = 0; i < `DTM_NUM_THR; i++)
      raw[i] = hys_cmp(center_temp_i, dtm_temp_t'(`DTM_THR_C >> (8 * i)),
                       `DTM_WARN_HYS_C, cmp.stable[i]);
    raw[6] = hys_cmp(center_temp_i, `DTM_SD_C, `DTM_SD_HYS_C,
                     cmp.stable[6]);
  end
  assign cmp.raw = raw;
  assign cmp.sample = powered;

  dtm_debounce #(.N(7), .DB_CYC(DB_CYC)) u_db (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmp(cmp)
  );

  wire [5:0] thermal_threshold_sense = cmp.stable[5:0];
  logic [5:0] sense_prev_q;
  wire [5:0] rise = thermal_threshold_sense & ~sense_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sense_prev_q <= 6'h00;
    else
      sense_prev_q <= thermal_threshold_sense;
  end

  // ************************************************************
  // flags, interrupt pin, shutdown
  // ************************************************************
  wire [5:0] flag_clr = wr_flag ? wb_dat_i[5:0] : 6'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      temp_irq_flag_q <= 6'h00;
    else
      temp_irq_flag_q <= (temp_irq_flag_q & ~flag_clr) | rise;
  end

  wire [5:0] flag_d = (temp_irq_flag_q & ~flag_clr) | rise;
  wire irq_any = |(flag_d & ~thermal_threshold_irq_mask_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_out_n <= 1'b1;
    else
      irq_out_n <= !irq_any;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thermal_shutdown_o <= 1'b0;
      monitor_power_o <= 1'b0;
    end
    else
    begin
      thermal_shutdown_o <= cmp.stable[6];
      monitor_power_o <= pwr_d == DTM_WIN;
    end
  end

  // ************************************************************
  // read data and acknowledge
  // ************************************************************
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h00000000;
    case (wb_adr_i)
      `DTM_CTRL_OFS: rmux[2:0] = ctrl_q;
      `DTM_FLAG_OFS: rmux[5:0] = temp_irq_flag_q;
      `DTM_MASK_OFS: rmux[5:0] = thermal_threshold_irq_mask_q;
      `DTM_STAT_OFS: rmux[7:0] = {powered, cmp.stable[6],
                                  thermal_threshold_sense};
      default: rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      rdat_q <= req ? rmux : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule

// >>> verification/dtm_top_sva.sv
// port checker of the thermal monitor control
`timescale 1ns/1ps
module dtm_top_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] center_temp_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_out_n,
  input wire logic monitor_power_o,
  input wire logic thermal_shutdown_o
);
  // ****************
  // port properties
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_rst_quiet: assert property ($fell(rst_i) |->
    !monitor_power_o && !thermal_shutdown_o && !wb_ack_o)
    else $error("outputs active after reset");
  a_rst_irq: assert property ($fell(rst_i) |-> irq_out_n ##1 irq_out_n)
    else $error("interrupt low after reset");
  a_sd_set: assert property ($rose(thermal_shutdown_o) |->
    $past(center_temp_i) >= 8'hA5) else $error("shutdown below limit");
  a_sd_clr: assert property ($fell(thermal_shutdown_o) |->
    $past(center_temp_i) <= 8'h96) else $error("shutdown released early");
  a_irq_cause: assert property ($fell(irq_out_n) |->
    $past(center_temp_i) >= 8'h50) else $error("interrupt while cool");
  c_sd: cover property ($rose(thermal_shutdown_o));
  c_irq: cover property ($fell(irq_out_n));
  c_pwr: cover property ($fell(monitor_power_o));
endmodule
bind dtm_top dtm_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .center_temp_i(center_temp_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_out_n(irq_out_n), .monitor_power_o(monitor_power_o),
  .thermal_shutdown_o(thermal_shutdown_o));

// >>> verification/dtm_top_tb_top.sv
// self-checking bench of the thermal monitor control
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module dtm_top_tb_top
  import dtm_pkg::*;
;
  // ****************
  // bench
  // ****************
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  dtm_temp_t temp = 8'h00;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, exp_q[$], msk_q[$];
  logic ack, irq_n, pwr, sd;
  int num_errors = 0, samples_checked = 0, on, off, i;
  dtm_top #(.DB_CYC(4), .WIN_CYC(20), .INT_CYC(60)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .center_temp_i(temp), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_out_n(irq_n),
    .monitor_power_o(pwr), .thermal_shutdown_o(sd));
  initial forever #2 clk_i = ~clk_i;
  task stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      num_errors++;
      stop_test;
    end
    {cyc, stb, we} <= 3'b000;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task settle(input dtm_temp_t t);
    temp <= t;
    repeat (12) @(posedge clk_i);
  endtask
  task cnt(input logic lv, output int n);
    n = 0;
    while (pwr === lv && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300)
    begin
      num_errors++;
      stop_test;
    end
  endtask
  // read results leave the note queue oldest first
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0)
    begin
      if (exp_q.size() == 0)
        `CHK(rdat, 32'hX)
      else
        `CHK(rdat & msk_q.pop_front(), exp_q.pop_front())
    end
  initial
  begin
    void'($urandom(48));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h1, 32'hFF);
    rd(4'h8, 32'h3F, 32'hFF);
    bus(1'b1, 4'h2, 32'hFF);
    rd(4'h2, 32'h0, 32'hFF);
    bus(1'b1, 4'h0, 32'h3);
    bus(1'b1, 4'h8, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      settle(8'h50 + 8'(15 * i) + 8'($urandom % 5));
      rd(4'hC, 32'h80 | ((32'h2 << i) - 1), 32'hFF);
      rd(4'h4, (32'h2 << i) - 1, 32'hFF);
    end
    `CHK(irq_n, 1'b0)
    settle(8'h97);
    rd(4'hC, 32'hBF, 32'hFF);
    settle(8'h96);
    rd(4'hC, 32'h9F, 32'hFF);
    bus(1'b1, 4'h4, 32'h3F);
    rd(4'h4, 32'h0, 32'hFF);
    `CHK(irq_n, 1'b1)
    settle(8'h9B);
    bus(1'b1, 4'h8, 32'h20);
    repeat (3) @(posedge clk_i);
    `CHK(irq_n, 1'b1)
    bus(1'b1, 4'h8, 32'h0);
    repeat (3) @(posedge clk_i);
    `CHK(irq_n, 1'b0)
    settle(8'hA4);
    `CHK(sd, 1'b0)
    settle(8'hA5);
    `CHK(sd, 1'b1)
    settle(8'h97);
    `CHK(sd, 1'b1)
    settle(8'h96);
    `CHK(sd, 1'b0)
    bus(1'b1, 4'h0, 32'h0);
    settle(8'h14);
    rd(4'hC, 32'h1F, 32'hFF);
    for (i = 1; i < 8; i += 6)
    begin
      bus(1'b1, 4'h0, 32'(i));
      cnt(1'b1, on);
      cnt(1'b0, off);
      cnt(1'b1, on);
      cnt(1'b0, off);
      `CHK(on, 20)
      `CHK(off, 40)
    end
    rd(4'hC, 32'h0, 32'h7F);
    stop_test;
  end
endmodule
